// ===== vbi_output_params.svh
/*
  constants for the vbi pass-through output block: register offsets,
  field positions, reset values and timing counts.
  assumes inclusion by bare name from the design, checker and bench files.
*/
`ifndef VBI_OUTPUT_PARAMS_SVH
`define VBI_OUTPUT_PARAMS_SVH

// ==========================================================
// register byte addresses (index times four)
`define TCTL_INDEX 8'h1b
`define TCTL_ADDR 12'h06c
`define OFC_ADDR 12'h048
`define HDLY_ADDR 12'h100
`define VDLY_ADDR 12'h104
`define STAT_ADDR 12'h108
`define OFC_INDEX 8'h12

// ==========================================================
// field positions
`define TCTL_LINE_EN_BIT 7
`define TCTL_BYTE_ORDER_BIT 6
`define OFC_FRAME_EN_BIT 0
`define OFC_PACKED_BIT 1

// ==========================================================
// reset values
`define TCTL_RESET 8'h00
`define OFC_RESET 8'h02
`define HDLY_RESET 10'h078
`define VDLY_RESET 10'h016
// synchroniser idle: video present, both syncs high, clock and samples low
`define SYNC_IDLE 12'he00

// ==========================================================
// timing: first vbi line and nominal words per line
`define VBI_FIRST_LINE 10'h00a
`define NTSC_LINES 10'h20d
`define NTSC_WORDS 845
`define PAL_WORDS 1070

// blue field values
`define BLUE_Y 8'h29
`define BLUE_CB 8'hf0
`define BLUE_CR 8'h6e

`endif

// ===== vbi_output_pkg.sv
/*
  types for the vbi pass-through output block.
  assumes nothing beyond the params header.
*/
package vbi_output_pkg;
  // output mode of the pixel port
  typedef enum logic [1:0] {
    MODE_DISABLED = 2'b00,
    MODE_LINE = 2'b01,
    MODE_FRAME = 2'b10
  } vbi_mode_t;

  // data kind currently on the port
  typedef enum logic [1:0] {
    SRC_IMAGE = 2'b00,
    SRC_VBI = 2'b01,
    SRC_BLUE = 2'b10
  } out_src_t;
endpackage

// ===== vbi_passthrough_output.sv
/*
  vbi_passthrough_output: output stage of the vbi pass-through path.
  selects decoded 4:2:2 image data, raw 8x samples or flat blue onto
  the 16-bit pixel port and drives the active, valid and qualified clock.
  assumes: sync pulses, sample clock and raw samples come from outside
  the mclk domain and are synchronised here; 4:2:2 pixels and the
  image vertical_active_flag come from decoder logic on mclk; registers over
  ahb-lite, single zero-wait word transfers.
*/
// Our own choice: the AHB-Lite slave port.
// Function
// [R1] raw 8-bit samples bypass all filters
// [R2] packed 16-bit or upper-lane 8-bit output
// [R3] packed: first byte upper lane, msb 15/7
// [R4] one 16-bit port, software byte order
// [R5] no pipeline delay on vbi samples
// [R6] samples not locked to horizontal sync
// [R7] three modes, disabled by default
// [R8] line mode: vsync end until vertical_active_flag
// [R9] frame mode: every line is vbi
// [R10] line enable bit in timing control
// [R11] horizontal_active_flag: one clock after hsync end
// [R12] valid high for whole vbi line
// [R13] qualified clock ungated during vbi
// [R14] line mode data invalid outside horizontal_active_flag
// [R15] image horizontal_active_flag delayed by horizontal delay
// [R16] 845 ntsc, 1070 pal words per line
// [R17] samples span burst to next hsync
// [R18] vertical delay sets vbi line extent
// [R19] late vsync starts vbi next line
// [R20] 525 lines, vbi lines 10-20, 273-282
// [R21] receiver accepts varying sample counts
// [R22] order bit 0: sample n upper lane
// [R23] frame mode: valid and actives held high
// [R24] frame mode wins over line mode
// [R25] no video present gives blue field
// [R26] reset clears both vbi enables
`timescale 1ns/100ps
`include "vbi_output_params.svh"

module vbi_passthrough_output
  import vbi_output_pkg::*;
#(
  parameter int WORDS_PER_LINE = `NTSC_WORDS
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // video timing and samples from outside
  input wire logic base_sample_clock_i,
  input wire logic horizontal_sync_pulse_n_i,
  input wire logic vertical_sync_pulse_n_i,
  input wire logic [7:0] raw_sample_i,
  input wire logic video_present_flag_i,
  // decoded image path on mclk
  input wire logic [15:0] image_data_i,
  input wire logic image_valid_i,
  input wire logic image_vertical_active_flag_i,
  // pixel port
  output logic [15:0] video_data_bus_o,
  output logic horizontal_active_flag_o,
  output logic vertical_active_flag_o,
  output logic pixel_valid_flag_o,
  output logic qualified_data_clock_o,
  output logic vbi_line_o
);

  // ==========================================================
  // register file
  logic [7:0] tctl_q;
  logic [7:0] ofc_q;
  logic [9:0] hdly_q;
  logic [9:0] vdly_q;
  logic wr_pend_q;
  logic [11:0] wr_addr_q;
  logic [15:0] word_cnt_q;
  logic [15:0] last_words_q;
  logic [9:0] line_q;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
    hit = (a == r);
  endfunction

  wire logic ahb_go = hsel_i && hready_i && htrans_i[1];

  // capture write address phase
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 12'h000;
    end else begin
      wr_pend_q <= ahb_go && hwrite_i;
      wr_addr_q <= haddr_i[11:0];
    end
  end

  // register writes in data phase
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      tctl_q <= `TCTL_RESET; // [R26]
      ofc_q <= `OFC_RESET; // [R26]
      hdly_q <= `HDLY_RESET;
      vdly_q <= `VDLY_RESET;
    end else if (wr_pend_q) begin
      if (hit(wr_addr_q, `TCTL_ADDR)) tctl_q <= hwdata_i[7:0]; // [R10]
      if (hit(wr_addr_q, `OFC_ADDR)) ofc_q <= hwdata_i[7:0];
      if (hit(wr_addr_q, `HDLY_ADDR)) hdly_q <= hwdata_i[9:0];
      if (hit(wr_addr_q, `VDLY_ADDR)) vdly_q <= hwdata_i[9:0];
    end
  end

  // read data registered from address phase; unmapped reads zero
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      hrdata_o <= 32'h0000_0000;
    end else if (ahb_go && !hwrite_i) begin
      if (hit(haddr_i[11:0], `TCTL_ADDR)) hrdata_o <= {24'h000000, tctl_q};
      else if (hit(haddr_i[11:0], `OFC_ADDR)) hrdata_o <= {24'h000000, ofc_q};
      else if (hit(haddr_i[11:0], `HDLY_ADDR)) hrdata_o <= {22'h000000, hdly_q};
      else if (hit(haddr_i[11:0], `VDLY_ADDR)) hrdata_o <= {22'h000000, vdly_q};
      else if (hit(haddr_i[11:0], `STAT_ADDR)) hrdata_o <= {last_words_q, 6'h00, line_q};
      else hrdata_o <= 32'h0000_0000;
    end
  end

  // always ready, always okay
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end
  end

  // ==========================================================
  // input synchronisers, two flops each
  logic [11:0] sync1_q;
  logic [11:0] sync2_q;
  logic clk_prev_q;
  logic hs_prev_q;
  logic vs_prev_q;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      // idle pin levels, so release gives no false sync edges
      sync1_q <= `SYNC_IDLE;
      sync2_q <= `SYNC_IDLE;
    end else begin
      sync1_q <= {video_present_flag_i, vertical_sync_pulse_n_i,
                  horizontal_sync_pulse_n_i, base_sample_clock_i, raw_sample_i};
      sync2_q <= sync1_q;
    end
  end

  wire logic [7:0] raw_s = sync2_q[7:0];
  wire logic clk_s = sync2_q[8];
  wire logic hs_n_s = sync2_q[9];
  wire logic vs_n_s = sync2_q[10];
  wire logic present_s = sync2_q[11];

  // edge history
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      clk_prev_q <= 1'b0;
      hs_prev_q <= 1'b1;
      vs_prev_q <= 1'b1;
    end else begin
      clk_prev_q <= clk_s;
      hs_prev_q <= hs_n_s;
      vs_prev_q <= vs_n_s;
    end
  end

  wire logic clk_rise = clk_s && !clk_prev_q;
  wire logic hs_lead = hs_prev_q && !hs_n_s;
  wire logic hs_trail = !hs_prev_q && hs_n_s;
  wire logic vs_trail = !vs_prev_q && vs_n_s;
  wire logic vs_lead = vs_prev_q && !vs_n_s;

  // ==========================================================
  // mode decode
  wire logic line_en = tctl_q[`TCTL_LINE_EN_BIT];
  wire logic order_rev = tctl_q[`TCTL_BYTE_ORDER_BIT];
  wire logic frame_en = ofc_q[`OFC_FRAME_EN_BIT];
  wire logic pack_en = ofc_q[`OFC_PACKED_BIT];
  vbi_mode_t mode;

  // frame mode has precedence
  always_comb begin
    if (frame_en) mode = MODE_FRAME; // [R24] [R9]
    else if (line_en) mode = MODE_LINE; // [R7]
    else mode = MODE_DISABLED;
  end

  // ==========================================================
  // horizontal timing on base clock edges
  logic hact_q;
  logic arm_q;
  logic vbi_q;
  logic vbi_pend_q;
  logic [9:0] hcnt_q;
  logic img_hact_q;

  // horizontal_active_flag starts one base clock after hsync trailing edge
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      hact_q <= 1'b0;
      arm_q <= 1'b0;
    end else if (hs_lead) begin
      hact_q <= 1'b0; // [R11] [R17]
      arm_q <= 1'b0;
    end else if (hs_trail) begin
      arm_q <= 1'b1;
    end else if (arm_q && clk_rise) begin
      hact_q <= 1'b1; // [R11]
      arm_q <= 1'b0;
    end
  end

  // image horizontal_active_flag after horizontal delay from hsync leading edge
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      hcnt_q <= 10'h000;
      img_hact_q <= 1'b0;
    end else if (hs_lead) begin
      hcnt_q <= 10'h000;
      img_hact_q <= 1'b0;
    end else if (clk_rise && !img_hact_q) begin
      hcnt_q <= hcnt_q + 10'h001;
      img_hact_q <= (hcnt_q + 10'h001 >= hdly_q); // [R15]
    end
  end

  // word count per line, vbi or not, kept for status
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      word_cnt_q <= 16'h0000;
      last_words_q <= 16'h0000;
    end else if (hs_lead) begin
      last_words_q <= word_cnt_q; // [R16] [R21]
      word_cnt_q <= 16'h0000;
    end else if (hact_q && clk_rise) begin
      word_cnt_q <= word_cnt_q + 16'h0001;
    end
  end

  // ==========================================================
  // vertical: line counter and vbi region
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      line_q <= 10'h000;
    end else if (vs_trail) begin
      line_q <= `VBI_FIRST_LINE; // [R20]
    end else if (hs_lead && line_q < `NTSC_LINES) begin
      line_q <= line_q + 10'h001;
    end
  end

  // vbi region from vsync end to vertical delay line count
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      vbi_q <= 1'b0;
      vbi_pend_q <= 1'b0;
    end else if (vs_trail) begin
      if (hact_q) vbi_pend_q <= 1'b1; // [R19]
      else vbi_q <= 1'b1; // [R8]
    end else if (vs_lead) begin
      // region never runs into the vertical sync pulse
      vbi_q <= 1'b0; // [R8]
      vbi_pend_q <= 1'b0;
    end else if (hs_lead && vbi_pend_q) begin
      vbi_q <= 1'b1; // [R19]
      vbi_pend_q <= 1'b0;
    end else if (hs_lead && line_q >= vdly_q) begin
      vbi_q <= 1'b0; // [R18]
    end else if (image_vertical_active_flag_i) begin
      vbi_q <= 1'b0; // [R8]
    end
  end

  // ==========================================================
  // byte pairing of raw samples, no alignment delay
  logic half_q;
  logic [7:0] first_q;
  logic [15:0] pair_q;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      half_q <= 1'b0;
      first_q <= 8'h00;
      pair_q <= 16'h0000;
    end else if (clk_rise) begin
      // raw samples straight from the input, unfiltered
      half_q <= ~half_q; // [R1] [R6]
      first_q <= raw_s;
      if (half_q) begin
        if (order_rev) pair_q <= {raw_s, first_q}; // [R22]
        else pair_q <= {first_q, raw_s}; // [R3] [R22]
      end
    end
  end

  // ==========================================================
  // output selection
  out_src_t src;
  logic in_vbi;

  always_comb begin
    in_vbi = (mode == MODE_FRAME) || (mode == MODE_LINE && vbi_q);
    if (!present_s) src = SRC_BLUE; // [R25]
    else if (in_vbi) src = SRC_VBI;
    else src = SRC_IMAGE;
  end

  // pixel port, shared by vbi and image data
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      video_data_bus_o <= 16'h0000;
    end else begin
      case (src)
        SRC_VBI: begin
          // packed pairs or single bytes on upper lane, no pipeline
          if (pack_en) video_data_bus_o <= pair_q; // [R2] [R4] [R5]
          else video_data_bus_o <= {raw_s, 8'h00}; // [R2]
        end
        SRC_BLUE: video_data_bus_o <= half_q ? {`BLUE_Y, `BLUE_CR} : {`BLUE_Y, `BLUE_CB};
        SRC_IMAGE: video_data_bus_o <= image_data_i; // [R4]
        default: video_data_bus_o <= 16'h0000;
      endcase
    end
  end

  // flags per mode
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      horizontal_active_flag_o <= 1'b0;
      vertical_active_flag_o <= 1'b0;
      pixel_valid_flag_o <= 1'b0;
      vbi_line_o <= 1'b0;
    end else begin
      vbi_line_o <= (src == SRC_VBI);
      if (mode == MODE_FRAME && present_s) begin
        horizontal_active_flag_o <= 1'b1; // [R23]
        vertical_active_flag_o <= 1'b1; // [R23]
        pixel_valid_flag_o <= 1'b1; // [R23]
      end else if (src == SRC_VBI) begin
        // outside horizontal_active_flag the data is invalid for the receiver
        horizontal_active_flag_o <= hact_q; // [R11] [R14]
        vertical_active_flag_o <= 1'b0;
        pixel_valid_flag_o <= 1'b1; // [R12]
      end else begin
        horizontal_active_flag_o <= img_hact_q; // [R15]
        vertical_active_flag_o <= image_vertical_active_flag_i;
        pixel_valid_flag_o <= image_valid_i && img_hact_q;
      end
    end
  end

  // qualified clock: free-running during vbi, gated by valid otherwise
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      qualified_data_clock_o <= 1'b0;
    end else if (src == SRC_VBI) begin
      qualified_data_clock_o <= clk_s; // [R13]
    end else begin
      qualified_data_clock_o <= clk_s && image_valid_i && img_hact_q;
    end
  end

endmodule

// ===== vbi_passthrough_output_asserts.sv
/*
  port checker for vbi_passthrough_output.
  assumes binding to the top module and single word ahb writes.
*/
`timescale 1ns/100ps
`include "vbi_output_params.svh"
module vbi_passthrough_output_asserts
#(
  parameter int WORDS_PER_LINE = `NTSC_WORDS
) (
  // clock, reset and bus
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  // video
  input wire logic horizontal_sync_pulse_n_i,
  input wire logic video_present_flag_i,
  input wire logic image_vertical_active_flag_i,
  input wire logic [15:0] video_data_bus_o,
  input wire logic horizontal_active_flag_o,
  input wire logic vertical_active_flag_o,
  input wire logic pixel_valid_flag_o,
  input wire logic qualified_data_clock_o,
  input wire logic vbi_line_o
);
  logic wp_q, line_q, frame_q, packed_q;
  logic [11:0] wa_q;
  logic [3:0] calm_q, nov_q, vact_q, qst_q;
  // ==========================================================
  // helper logic
  // mode bits shadowed from bus writes
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      wp_q <= 1'b0;
      line_q <= 1'b0;
      frame_q <= 1'b0;
      packed_q <= 1'b1;
    end else begin
      wp_q <= hsel_i && hready_i && htrans_i[1] && hwrite_i;
      if (hsel_i && hready_i && htrans_i[1]) wa_q <= haddr_i[11:0];
      if (wp_q && wa_q == `TCTL_ADDR) line_q <= hwdata_i[`TCTL_LINE_EN_BIT];
      if (wp_q && wa_q == `OFC_ADDR) begin
        frame_q <= hwdata_i[`OFC_FRAME_EN_BIT];
        packed_q <= hwdata_i[`OFC_PACKED_BIT];
      end
    end
  end
  // settle, no-video, vertical_active_flag and still-clock counters
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      calm_q <= 4'h0;
      nov_q <= 4'h0;
      vact_q <= 4'h0;
      qst_q <= 4'h0;
    end else begin
      if (wp_q || !video_present_flag_i) calm_q <= 4'h0;
      else if (calm_q != 4'hf) calm_q <= calm_q + 4'h1;
      nov_q <= video_present_flag_i ? 4'h0 : nov_q + {3'h0, nov_q != 4'hf};
      vact_q <= image_vertical_active_flag_i ? vact_q + {3'h0, vact_q != 4'hf} : 4'h0;
      // still-clock run counted only inside vbi
      if (!vbi_line_o || !$stable(qualified_data_clock_o)) qst_q <= 4'h0;
      else qst_q <= qst_q + {3'h0, qst_q != 4'hf};
    end
  end
  // ==========================================================
  // assertions
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  sequence hs_lead_s;
    $fell(horizontal_sync_pulse_n_i) && vbi_line_o && !frame_q;
  endsequence
  sequence act_drop_s;
    ##[1:10] !horizontal_active_flag_o;
  endsequence
  reset_clear_a: assert property (
    $fell(rst_i) |-> !vbi_line_o && !pixel_valid_flag_o) else $error("vbi out of reset");
  mode_off_a: assert property (
    calm_q > 4'hb && !frame_q && !line_q |-> !vbi_line_o) else $error("vbi while disabled");
  frame_flags_a: assert property (
    calm_q > 4'hb && frame_q |-> vbi_line_o && pixel_valid_flag_o
    && horizontal_active_flag_o && vertical_active_flag_o) else $error("frame flags low");
  frame_wins_a: assert property (
    calm_q > 4'hb && frame_q && line_q |-> vbi_line_o) else $error("line beat frame");
  valid_whole_a: assert property (
    vbi_line_o |-> pixel_valid_flag_o) else $error("valid low in vbi");
  low_lane_a: assert property (
    calm_q > 4'hb && vbi_line_o && !packed_q |-> video_data_bus_o[7:0] == 8'h00)
    else $error("low lane busy");
  blue_field_a: assert property (
    nov_q > 4'h8 |-> !vbi_line_o) else $error("vbi without video");
  line_end_a: assert property (
    vact_q > 4'h4 && !frame_q |-> !vbi_line_o) else $error("vbi in image");
  qualified_data_clock_run_a: assert property (
    vbi_line_o |-> qst_q < 4'hb) else $error("qualified_data_clock gated in vbi");
  hs_drop_a: assert property (
    hs_lead_s |-> act_drop_s) else $error("horizontal_active_flag high at hsync");
endmodule

bind vbi_passthrough_output vbi_passthrough_output_asserts #(.WORDS_PER_LINE(WORDS_PER_LINE))
  i_vbi_passthrough_output_asserts (.mclk_i, .rst_i, .hsel_i, .haddr_i, .htrans_i,
  .hwrite_i, .hwdata_i, .hready_i, .horizontal_sync_pulse_n_i, .video_present_flag_i,
  .image_vertical_active_flag_i, .video_data_bus_o, .horizontal_active_flag_o, .vertical_active_flag_o,
  .pixel_valid_flag_o, .qualified_data_clock_o, .vbi_line_o);

// ===== vbi_source_model.sv
/*
  vbi_source_model: video front end with a short line and frame,
  plus a capture-side word counter. assumes a free running sample clock.
*/
`timescale 1ns/100ps
module vbi_source_model (
  // from the block
  input wire logic hact_i,
  input wire logic vbi_i,
  // to the block
  output logic base_clk_o,
  output logic hsync_n_o,
  output logic vsync_n_o,
  output logic [7:0] sample_o,
  // capture side
  output logic [15:0] words_o
);
  int pos = 0;
  int line = 0;
  logic [15:0] cnt_q = 16'h0000;
  // free running clock, phase unrelated to mclk
  initial begin
    base_clk_o = 1'b0;
    hsync_n_o = 1'b1;
    vsync_n_o = 1'b1;
    sample_o = 8'h00;
    words_o = 16'h0000;
    #37;
    forever #400 base_clk_o = ~base_clk_o;
  end
  // 40 samples a line, 8 lines a frame, two of vsync
  always @(posedge base_clk_o) begin
    pos <= (pos == 39) ? 0 : pos + 1;
    if (pos == 39) line <= (line == 7) ? 0 : line + 1;
    hsync_n_o <= (pos >= 4);
    vsync_n_o <= (line >= 2);
    sample_o <= sample_o + 8'h01;
    if (pos == 0) begin
      words_o <= cnt_q;
      cnt_q <= 16'h0000;
    end else if (hact_i && vbi_i) cnt_q <= cnt_q + 16'h0001;
  end
endmodule

// ===== vbi_passthrough_output_tb.sv
/*
  vbi_passthrough_output_tb: self-checking bench over ahb-lite.
  assumes the source model and the bound checker.
*/
`timescale 1ns/100ps
`include "vbi_output_params.svh"
module vbi_passthrough_output_tb;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic hsel_i = 1'b0;
  logic hwrite_i = 1'b0;
  logic [1:0] htrans_i = 2'b00;
  logic [31:0] haddr_i = 32'h00000000;
  logic [31:0] hwdata_i = 32'h00000000;
  logic video_present_flag_i = 1'b1;
  logic image_vertical_active_flag_i = 1'b0;
  logic [31:0] hrdata_o, q;
  logic hreadyout_o, hresp_o, base_sample_clock_i, vbi_line_o;
  logic horizontal_sync_pulse_n_i, vertical_sync_pulse_n_i;
  logic [7:0] raw_sample_i;
  logic [15:0] video_data_bus_o, words;
  logic horizontal_active_flag_o, vertical_active_flag_o;
  logic pixel_valid_flag_o, qualified_data_clock_o;
  int n_errors = 0;
  int checked = 0;
  time t0;
  // 40 per model line, less 4 in sync, 1 lead-in clock, 1 flag latency
  localparam logic [15:0] LINE_WORDS = 16'h0022;
  // ==========================================================
  // design and source
  vbi_passthrough_output i_vbi_passthrough_output (.mclk_i, .rst_i, .hsel_i, .haddr_i,
    .htrans_i, .hwrite_i, .hsize_i(3'h2), .hwdata_i, .hready_i(hreadyout_o), .hrdata_o,
    .hreadyout_o, .hresp_o, .base_sample_clock_i, .horizontal_sync_pulse_n_i,
    .vertical_sync_pulse_n_i, .raw_sample_i, .video_present_flag_i,
    .image_data_i(16'h8080), .image_valid_i(1'b1), .image_vertical_active_flag_i, .video_data_bus_o,
    .horizontal_active_flag_o, .vertical_active_flag_o, .pixel_valid_flag_o,
    .qualified_data_clock_o, .vbi_line_o);
  vbi_source_model i_vbi_source_model (.hact_i(horizontal_active_flag_o),
    .vbi_i(vbi_line_o), .base_clk_o(base_sample_clock_i),
    .hsync_n_o(horizontal_sync_pulse_n_i), .vsync_n_o(vertical_sync_pulse_n_i),
    .sample_o(raw_sample_i), .words_o(words));
  // ==========================================================
  // shared tasks
  task summarize;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input bit ok, input string m);
    checked++;
    if (!ok) begin
      n_errors++;
      $display("FAIL %0t %s", $time, m);
    end
  endtask
  // one single transfer, address phase then data phase
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    hsel_i <= 1'b1;
    htrans_i <= 2'b10;
    haddr_i <= {20'h00000, a};
    hwrite_i <= w;
    @(posedge mclk_i);
    while (hreadyout_o !== 1'b1) @(posedge mclk_i);
    hsel_i <= 1'b0;
    htrans_i <= 2'b00;
    hwdata_i <= d;
    @(posedge mclk_i);
    while (hreadyout_o !== 1'b1) @(posedge mclk_i);
    q = hrdata_o;
  endtask
  task wait_vbi(input logic v);
    for (int i = 0; i < 4000 && vbi_line_o !== v; i++) @(posedge mclk_i);
  endtask
  // ==========================================================
  // scenarios
  task t_regs;
    bus(1'b0, `TCTL_ADDR, 32'h0);
    chk(q === {24'h000000, `TCTL_RESET}, "timing control reset");
    chk(hresp_o === 1'b0, "response not okay");
    bus(1'b0, `OFC_ADDR, 32'h0);
    chk(q === {24'h000000, `OFC_RESET}, "ofc reset");
    bus(1'b1, `TCTL_ADDR, 32'h80);
    bus(1'b0, `TCTL_ADDR, 32'h0);
    chk(q === 32'h00000080, "timing control readback");
    bus(1'b1, `TCTL_ADDR, 32'h0);
    bus(1'b0, 12'h200, 32'h0);
    chk(q === 32'h0, "unmapped read");
    wait_vbi(1'b1);
    chk(vbi_line_o === 1'b0, "vbi while disabled");
    $display("test regs done");
  endtask
  task t_line;
    bus(1'b1, `TCTL_ADDR, 32'h80);
    wait_vbi(1'b1);
    chk(vbi_line_o === 1'b1, "no vbi line");
    chk(pixel_valid_flag_o === 1'b1, "valid low");
    repeat (2) @(negedge horizontal_sync_pulse_n_i);
    @(posedge mclk_i);
    chk(words === LINE_WORDS, "words on line");
    bus(1'b0, `STAT_ADDR, 32'h0);
    chk(q[31:16] === LINE_WORDS, "status word count");
    image_vertical_active_flag_i <= 1'b1;
    wait_vbi(1'b0);
    repeat (8) @(posedge mclk_i);
    chk(vbi_line_o === 1'b0, "vbi past vertical_active_flag");
    chk(vertical_active_flag_o === 1'b1, "image vertical_active_flag low");
    chk(video_data_bus_o === 16'h8080, "image data lost");
    image_vertical_active_flag_i <= 1'b0;
    bus(1'b1, `VDLY_ADDR, 32'h0c);
    wait_vbi(1'b1);
    t0 = $time;
    wait_vbi(1'b0);
    chk(vbi_line_o === 1'b0, "region past vertical_delay_count");
    chk($time - t0 > 63000 && $time - t0 < 65000, "region not two lines");
    $display("test line done");
  endtask
  task t_frame;
    bus(1'b1, `TCTL_ADDR, 32'h0);
    bus(1'b1, `OFC_ADDR, 32'h3);
    wait_vbi(1'b1);
    chk(vbi_line_o === 1'b1, "frame no vbi");
    chk((horizontal_active_flag_o & vertical_active_flag_o) === 1'b1, "flags");
    repeat (4) @(posedge qualified_data_clock_o);
    @(posedge mclk_i);
    chk(video_data_bus_o[7:0] === video_data_bus_o[15:8] + 8'h01, "order 0");
    bus(1'b1, `TCTL_ADDR, 32'hc0);
    repeat (4) @(posedge qualified_data_clock_o);
    @(posedge mclk_i);
    chk(vbi_line_o === 1'b1, "frame lost");
    chk(video_data_bus_o[15:8] === video_data_bus_o[7:0] + 8'h01, "order 1");
    bus(1'b1, `OFC_ADDR, 32'h1);
    repeat (4) @(posedge qualified_data_clock_o);
    @(posedge mclk_i);
    chk(video_data_bus_o[7:0] === 8'h00, "unpacked low lane");
    $display("test frame done");
  endtask
  task t_blue;
    video_present_flag_i <= 1'b0;
    wait_vbi(1'b0);
    repeat (12) @(posedge mclk_i);
    chk(vbi_line_o === 1'b0, "vbi without video");
    chk(video_data_bus_o[15:8] === `BLUE_Y, "no blue field");
    video_present_flag_i <= 1'b1;
    wait_vbi(1'b1);
    chk(vbi_line_o === 1'b1, "vbi not back");
    $display("test blue done");
  endtask
  // ==========================================================
  // clock, main sequence and watchdog
  initial begin
    forever #50 mclk_i = ~mclk_i;
  end
  initial begin
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    t_regs;
    t_line;
    t_frame;
    t_blue;
    summarize;
  end
  initial begin
    #6000000;
    n_errors++;
    $display("FAIL %0t watchdog", $time);
    summarize;
  end
endmodule
